/* File: port_far_end.sv */
// Far-side pin model: resolves driven pins, lets released ones wander
`timescale 1ns/1ps
module port_far_end #(
    parameter int W = 6
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] pin_o,
    input  wire logic [W-1:0] pin_oe,
    input  wire logic [W-1:0] ext,
    input  wire logic [W-1:0] ext_en,
    output logic      [W-1:0] pin_i
);
    logic [W-1:0] float_q = '0; // Level of lines nobody drives
    // Undriven lines flip every cycle so stale values never pass
    always_ff @(posedge clk) begin
        float_q <= ~float_q;
    end
    // Device drive wins, then far side, else floating
    always_comb begin
        for (int b = 0; b < W; b++) begin
            pin_i[b] = pin_oe[b] ? pin_o[b] : (ext_en[b] ? ext[b] : float_q[b]);
        end
    end
endmodule

/* File: serial_xbar.sv */
// Digital crossbar between serial and general pins and core serial channels
`timescale 1ns/1ps
module serial_xbar #(
    parameter int PINS = 6
) (
    input  wire logic                  cfg_done,
    input  wire logic [PINS*4-1:0]     cfg,
    input  wire logic [PINS-1:0]       pin_in,
    input  wire logic [2:0]            ch_rx,
    output logic      [2:0]            ch_tx,
    output logic      [PINS-1:0]       pin_out,
    output logic      [PINS-1:0]       pin_oe
);
    if (PINS != typec_mux_pkg::XB_PINS) begin : g_chk
        $error("serial_xbar serves exactly six pins");
    end

    // Mapping; lowest numbered input pin wins a shared channel
    always_comb begin
        logic [1:0] chan;
        chan    = typec_mux_pkg::CH_NONE;
        ch_tx   = '1;      // Idle mark on unused channels
        pin_out = '1;
        pin_oe  = '0;
        if (!cfg_done) begin
            // Power-up bypass for daisy chaining
            pin_out[typec_mux_pkg::XB_SER_TX] = pin_in[typec_mux_pkg::XB_SER_RX];
            pin_oe[typec_mux_pkg::XB_SER_TX]  = 1'b1;
        end else begin
            for (int p = PINS - 1; p >= 0; p--) begin
                chan = cfg[p*4+typec_mux_pkg::XB_CHAN +: 2];
                if (chan != typec_mux_pkg::CH_NONE) begin
                    if (cfg[p*4+typec_mux_pkg::XB_DIR]) begin
                        // Pin is a crossbar output
                        pin_out[p] = ch_rx[chan];
                        pin_oe[p]  = cfg[p*4+typec_mux_pkg::XB_OE];
                    end else begin
                        // Pin is a crossbar input
                        ch_tx[chan] = pin_in[p];
                    end
                end
            end
        end
    end
endmodule

/* File: sync_bank.sv */
// Two-flop synchronisers for pins from outside the core clock domain
`timescale 1ns/1ps
module sync_bank #(
    parameter int W = 6
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;  // First stage, read only by second stage

    if (W < 1) begin : g_chk
        $error("sync_bank width must be positive");
    end

    // Two stages, idle-high after reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= '1;
            q      <= '1;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

/* File: typec_mux_pkg.sv */
// Constants, register map and source codes for the port data multiplexer control
// Notes on behaviour
// - Orientation swaps top and bottom pair assignments
// - Orientation plus chosen interface select pin outputs
// - Sideband crossbar flips its pins with orientation
// - First members to positive pins, and to sideband A, or to sideband B when flipped
// - Core channels fixed to top, bottom, sideband
// - Firmware maps serial and general pins to channels
// - Default crossbar loops serial receive to transmit
// - Serial buffers each have a tri-state control
// - Aux serial pair may be analog pass instead
// - Core signals sampled and driven on core clock
// - High-speed pairs never pass this multiplexer
// - Setting picks one of two cable-power limits
package typec_mux_pkg;
    // Register bus geometry
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 32;
    // Register offsets
    localparam logic [7:0]  REG_ROUTE  = 8'h00;
    localparam logic [7:0]  REG_CTRL   = 8'h04;
    localparam logic [7:0]  REG_XBAR   = 8'h08;
    localparam logic [7:0]  REG_STATUS = 8'h0C;
    // Route register fields
    localparam int          SRC_W      = 4;
    localparam int          ROUTE_PRI  = 0;
    localparam int          ROUTE_SEC  = 4;
    localparam int          ROUTE_SB   = 8;
    localparam int          ROUTE_W    = 12;
    // Control register bits
    localparam int          CTRL_ILIM  = 0;
    localparam int          CTRL_AUXAN = 1;
    localparam int          CTRL_XBCFG = 2;
    localparam int          CTRL_W     = 3;
    // Crossbar register, one nibble per pin
    localparam int          XB_FLD_W   = 4;
    localparam int          XB_CHAN    = 0;
    localparam int          XB_DIR     = 2;
    localparam int          XB_OE      = 3;
    localparam int          XB_PINS    = 6;
    // Status register fields
    localparam int          ST_ORIENT  = 0;
    localparam int          ST_TOP     = 4;
    localparam int          ST_BOT     = 8;
    localparam int          ST_SB      = 12;
    // Reset values
    localparam logic [ROUTE_W-1:0] ROUTE_RST = 12'h000;
    localparam logic [CTRL_W-1:0]  CTRL_RST  = 3'h0;
    localparam logic [23:0]        XBAR_RST  = 24'h000000;
    // Port pin indices
    localparam int          PIN_TOP_POS = 0;
    localparam int          PIN_TOP_NEG = 1;
    localparam int          PIN_BOT_POS = 2;
    localparam int          PIN_BOT_NEG = 3;
    localparam int          PIN_SB_A    = 4;
    localparam int          PIN_SB_B    = 5;
    localparam int          PORT_PINS   = 6;
    // Crossbar pin indices
    localparam int          XB_SER_RX   = 0;
    localparam int          XB_SER_TX   = 1;
    localparam int          XB_AUX_P2R  = 2;
    localparam int          XB_AUX_R2P  = 3;
    localparam int          XB_GIO0     = 4;
    localparam int          XB_GIO1     = 5;
    // Core serial channels
    localparam int          NUM_CH      = 3;
    localparam logic [1:0]  CH_NONE     = 2'h3;
    // Switch select vector width, bit n is source n+1
    localparam int          SEL_W       = 8;
    // System-side sources
    typedef enum logic [3:0] {
        SRC_NONE        = 4'h0,
        SRC_ROOT        = 4'h1,
        SRC_LOWSPEED    = 4'h2,
        SRC_DEBUG_WIRE  = 4'h3,
        SRC_DIAG_AB     = 4'h4,
        SRC_DIAG_CD     = 4'h5,
        SRC_AUX_CHAN    = 4'h6,
        SRC_CORE_SERIAL = 4'h7,
        SRC_AUX_SERIAL  = 4'h8
    } src_e;
endpackage

/* File: typec_port_data_mux_control.sv */
// Top of the port data multiplexer control: registers, routing, pin drive
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
module typec_port_data_mux_control #(
    parameter int XB_PINS = 6
) (
    input  wire logic                                  CLK_SYS,
    input  wire logic                                  RST_B,
    input  wire logic [typec_mux_pkg::ADDR_W-1:0]      REG_ADDR,
    input  wire logic [typec_mux_pkg::DATA_W-1:0]      REG_WDATA,
    input  wire logic                                  REG_WR,
    input  wire logic                                  REG_RD,
    output logic      [typec_mux_pkg::DATA_W-1:0]      REG_RDATA,
    input  wire logic                                  ORIENT_FLIP,
    output logic      [typec_mux_pkg::SEL_W-1:0]       SW_TOP_SEL,
    output logic      [typec_mux_pkg::SEL_W-1:0]       SW_BOTTOM_SEL,
    output logic      [typec_mux_pkg::SEL_W-1:0]       SW_SIDEBAND_SEL,
    output logic                                       SIDEBAND_CROSS,
    input  wire logic [typec_mux_pkg::PORT_PINS-1:0]   PORT_PIN_I,
    output logic      [typec_mux_pkg::PORT_PINS-1:0]   PORT_PIN_O,
    output logic      [typec_mux_pkg::PORT_PINS-1:0]   PORT_PIN_OE,
    input  wire logic [XB_PINS-1:0]                    XB_PIN_I,
    output logic      [XB_PINS-1:0]                    XB_PIN_O,
    output logic      [XB_PINS-1:0]                    XB_PIN_OE,
    output logic                                       AUX_ANALOG_PASS,
    output logic                                       CABLE_POWER_CURRENT_LIMIT
);
    if (XB_PINS != typec_mux_pkg::XB_PINS) begin : g_chk
        $error("crossbar pin count must be six");
    end

    // Legal sources on a USB D+/D- pair; no high-speed source exists
    function automatic logic usb_ok(input logic [3:0] s);
        usb_ok = (s >= typec_mux_pkg::SRC_ROOT) && (s <= typec_mux_pkg::SRC_CORE_SERIAL);
    endfunction

    // Legal sources on the sideband pair
    function automatic logic sb_ok(input logic [3:0] s);
        sb_ok = (s >= typec_mux_pkg::SRC_DEBUG_WIRE) && (s <= typec_mux_pkg::SRC_AUX_SERIAL);
    endfunction

    // One-hot switch vector for a source, zero for none
    function automatic logic [7:0] onehot(input logic [3:0] s);
        onehot = (s == typec_mux_pkg::SRC_NONE) ? 8'h00 : (8'h01 << (s - 4'h1));
    endfunction

    // Software state
    logic [typec_mux_pkg::ROUTE_W-1:0]     route_q;   // Pair source choices
    logic [typec_mux_pkg::CTRL_W-1:0]      ctrl_q;    // Limit, aux mode, crossbar ready
    logic [XB_PINS*4-1:0]                  xbar_q;    // Crossbar mapping
    logic [typec_mux_pkg::DATA_W-1:0]      rdata_d;   // Read mux
    // Synchronised pins
    logic [typec_mux_pkg::PORT_PINS-1:0]   pin_s;
    logic [XB_PINS-1:0]                    xb_s;
    // Routing decisions
    logic [3:0]                            pri_src;
    logic [3:0]                            sec_src;
    logic [3:0]                            sb_raw;
    logic [3:0]                            top_src;
    logic [3:0]                            bot_src;
    logic [3:0]                            sb_src;
    logic                                  aux_dig;   // Aux pair buffered on sideband
    logic                                  aux_an;    // Aux pair as analog switch
    logic                                  xb_cfg;    // Firmware has configured crossbar
    // Channel signals
    logic [2:0]                            ch_rx;
    logic [2:0]                            ch_tx;
    logic [XB_PINS-1:0]                    xb_out;
    logic [XB_PINS-1:0]                    xb_oe;
    // Next pin drive
    logic [typec_mux_pkg::PORT_PINS-1:0]   pin_o_d;
    logic [typec_mux_pkg::PORT_PINS-1:0]   pin_oe_d;
    logic [XB_PINS-1:0]                    xb_o_d;
    logic [XB_PINS-1:0]                    xb_oe_d;
    // Sideband pin roles after crossing
    int                                    sb_first;
    int                                    sb_second;
    // Edges with reset released, for checks
    logic [3:0]                            age_q;

    // Register decode
    wire wr_route = REG_WR && (REG_ADDR == typec_mux_pkg::REG_ROUTE);
    wire wr_ctrl  = REG_WR && (REG_ADDR == typec_mux_pkg::REG_CTRL);
    wire wr_xbar  = REG_WR && (REG_ADDR == typec_mux_pkg::REG_XBAR);

    // Field extraction
    assign pri_src = route_q[typec_mux_pkg::ROUTE_PRI +: typec_mux_pkg::SRC_W];
    assign sec_src = route_q[typec_mux_pkg::ROUTE_SEC +: typec_mux_pkg::SRC_W];
    assign sb_raw  = route_q[typec_mux_pkg::ROUTE_SB +: typec_mux_pkg::SRC_W];
    assign aux_an  = ctrl_q[typec_mux_pkg::CTRL_AUXAN];
    assign xb_cfg  = ctrl_q[typec_mux_pkg::CTRL_XBCFG];

    // Flipped plug puts the primary choice on the bottom pair
    assign top_src = ORIENT_FLIP ? sec_src : pri_src;
    assign bot_src = ORIENT_FLIP ? pri_src : sec_src;

    // Sideband members follow orientation
    assign sb_first  = ORIENT_FLIP ? typec_mux_pkg::PIN_SB_B : typec_mux_pkg::PIN_SB_A;
    assign sb_second = ORIENT_FLIP ? typec_mux_pkg::PIN_SB_A : typec_mux_pkg::PIN_SB_B;
    assign sb_src    = sb_ok(sb_raw) ? sb_raw : typec_mux_pkg::SRC_NONE;
    assign aux_dig   = (sb_src == typec_mux_pkg::SRC_AUX_SERIAL) && !aux_an;

    // Channel receive from negative or second member pins
    assign ch_rx[0] = pin_s[typec_mux_pkg::PIN_TOP_NEG];
    assign ch_rx[1] = pin_s[typec_mux_pkg::PIN_BOT_NEG];
    assign ch_rx[2] = pin_s[sb_second];

    // Input synchronisers
    sync_bank #(
        .W (typec_mux_pkg::PORT_PINS)
    ) u_port_sync (
        .clk   (CLK_SYS),
        .rst_b (RST_B),
        .d     (PORT_PIN_I),
        .q     (pin_s)
    );

    sync_bank #(
        .W (XB_PINS)
    ) u_xb_sync (
        .clk   (CLK_SYS),
        .rst_b (RST_B),
        .d     (XB_PIN_I),
        .q     (xb_s)
    );

    // Firmware crossbar
    serial_xbar #(
        .PINS (XB_PINS)
    ) u_xbar (
        .cfg_done (xb_cfg),
        .cfg      (xbar_q),
        .pin_in   (xb_s),
        .ch_rx    (ch_rx),
        .ch_tx    (ch_tx),
        .pin_out  (xb_out),
        .pin_oe   (xb_oe)
    );

    // Port pin drive; only transmit members are ever driven
    always_comb begin
        pin_o_d  = '1;
        pin_oe_d = '0;
        // Channel 0 on the top positive pin
        pin_o_d[typec_mux_pkg::PIN_TOP_POS]  = ch_tx[0];
        pin_oe_d[typec_mux_pkg::PIN_TOP_POS] = usb_ok(top_src) && (top_src == typec_mux_pkg::SRC_CORE_SERIAL);
        // Channel 1 on the bottom positive pin
        pin_o_d[typec_mux_pkg::PIN_BOT_POS]  = ch_tx[1];
        pin_oe_d[typec_mux_pkg::PIN_BOT_POS] = usb_ok(bot_src) && (bot_src == typec_mux_pkg::SRC_CORE_SERIAL);
        // Channel 2 or buffered aux on the first sideband member
        if (sb_src == typec_mux_pkg::SRC_CORE_SERIAL) begin
            pin_o_d[sb_first]  = ch_tx[2];
            pin_oe_d[sb_first] = 1'b1;
        end else if (aux_dig) begin
            pin_o_d[sb_first]  = xb_s[typec_mux_pkg::XB_AUX_R2P];
            pin_oe_d[sb_first] = xbar_q[typec_mux_pkg::XB_AUX_R2P*4+typec_mux_pkg::XB_OE];
        end
    end

    // Crossbar pin drive; buffered aux path overrides mapping of the aux pair
    always_comb begin
        xb_o_d  = xb_out;
        xb_oe_d = xb_oe;
        if (aux_dig) begin
            xb_o_d[typec_mux_pkg::XB_AUX_P2R]  = pin_s[sb_second];
            xb_oe_d[typec_mux_pkg::XB_AUX_P2R] = xbar_q[typec_mux_pkg::XB_AUX_P2R*4+typec_mux_pkg::XB_OE];
            xb_oe_d[typec_mux_pkg::XB_AUX_R2P] = 1'b0;
        end
    end

    // Read mux, unmapped offsets read zero
    always_comb begin
        rdata_d = '0;
        case (REG_ADDR)
            typec_mux_pkg::REG_ROUTE: rdata_d[typec_mux_pkg::ROUTE_W-1:0] = route_q;
            typec_mux_pkg::REG_CTRL:  rdata_d[typec_mux_pkg::CTRL_W-1:0]  = ctrl_q;
            typec_mux_pkg::REG_XBAR:  rdata_d[XB_PINS*4-1:0]              = xbar_q;
            typec_mux_pkg::REG_STATUS: begin
                rdata_d[typec_mux_pkg::ST_ORIENT]    = ORIENT_FLIP;
                rdata_d[typec_mux_pkg::ST_TOP +: 4]  = usb_ok(top_src) ? top_src : typec_mux_pkg::SRC_NONE;
                rdata_d[typec_mux_pkg::ST_BOT +: 4]  = usb_ok(bot_src) ? bot_src : typec_mux_pkg::SRC_NONE;
                rdata_d[typec_mux_pkg::ST_SB +: 4]   = sb_src;
            end
            default: rdata_d = '0;
        endcase
    end

    // Register writes
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            route_q <= typec_mux_pkg::ROUTE_RST;
            ctrl_q  <= typec_mux_pkg::CTRL_RST;
            xbar_q  <= typec_mux_pkg::XBAR_RST;
        end else begin
            if (wr_route) route_q <= REG_WDATA[typec_mux_pkg::ROUTE_W-1:0];
            if (wr_ctrl)  ctrl_q  <= REG_WDATA[typec_mux_pkg::CTRL_W-1:0];
            if (wr_xbar)  xbar_q  <= REG_WDATA[XB_PINS*4-1:0];
        end
    end

    // Read data, valid in the cycle after the strobe only
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) REG_RDATA <= '0;
        else        REG_RDATA <= REG_RD ? rdata_d : '0;
    end

    // Switch closures and configuration outputs
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            SW_TOP_SEL                <= '0;
            SW_BOTTOM_SEL             <= '0;
            SW_SIDEBAND_SEL           <= '0;
            SIDEBAND_CROSS            <= 1'b0;
            AUX_ANALOG_PASS           <= 1'b0;
            CABLE_POWER_CURRENT_LIMIT <= 1'b0;
        end else begin
            SW_TOP_SEL                <= usb_ok(top_src) ? onehot(top_src) : '0;
            SW_BOTTOM_SEL             <= usb_ok(bot_src) ? onehot(bot_src) : '0;
            SW_SIDEBAND_SEL           <= onehot(sb_src);
            SIDEBAND_CROSS            <= ORIENT_FLIP;
            AUX_ANALOG_PASS           <= aux_an;
            CABLE_POWER_CURRENT_LIMIT <= ctrl_q[typec_mux_pkg::CTRL_ILIM];
        end
    end

    // Registered pin drive in the core clock domain
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            PORT_PIN_O  <= '1;
            PORT_PIN_OE <= '0;
            XB_PIN_O    <= '1;
            XB_PIN_OE   <= '0;
        end else begin
            PORT_PIN_O  <= pin_o_d;
            PORT_PIN_OE <= pin_oe_d;
            XB_PIN_O    <= xb_o_d;
            XB_PIN_OE   <= xb_oe_d;
        end
    end

    // Edges since reset release, saturating
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B)               age_q <= 4'h0;
        else if (age_q != 4'hF)   age_q <= age_q + 4'h1;
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);

    sequence s_wr_ctrl;
        REG_WR && (REG_ADDR == typec_mux_pkg::REG_CTRL);
    endsequence

    sequence s_rd_ctrl;
        REG_RD && (REG_ADDR == typec_mux_pkg::REG_CTRL);
    endsequence

    AST_ONE_SOURCE: assert property ($onehot0(SW_TOP_SEL) && $onehot0(SW_BOTTOM_SEL)
        && $onehot0(SW_SIDEBAND_SEL)) else $error("more than one source on a pin");

    AST_SWAP: assert property ($rose(ORIENT_FLIP) && $stable(route_q) && $past(RST_B)
        |=> (SW_TOP_SEL == $past(SW_BOTTOM_SEL)) && (SW_BOTTOM_SEL == $past(SW_TOP_SEL)))
        else $error("top and bottom not exchanged on flip");

    AST_SB_CROSS: assert property ($rose(ORIENT_FLIP) |=> SIDEBAND_CROSS [*1] ##0
        !$past(SIDEBAND_CROSS)) else $error("sideband crossbar missed flip");

    AST_ILLEGAL: assert property ((top_src == typec_mux_pkg::SRC_AUX_SERIAL)
        |=> (SW_TOP_SEL == '0) && !PORT_PIN_OE[typec_mux_pkg::PIN_TOP_POS])
        else $error("aux serial reached a top pin");

    AST_CORE_CH0: assert property ((top_src == typec_mux_pkg::SRC_CORE_SERIAL)
        |=> PORT_PIN_OE[typec_mux_pkg::PIN_TOP_POS] && !PORT_PIN_OE[typec_mux_pkg::PIN_TOP_NEG])
        else $error("channel 0 not on top positive pin");

    AST_RDBACK: assert property (s_wr_ctrl ##1 s_rd_ctrl
        |=> REG_RDATA[typec_mux_pkg::CTRL_W-1:0] == $past(REG_WDATA[typec_mux_pkg::CTRL_W-1:0], 2))
        else $error("control readback wrong");

    AST_ILIM: assert property (s_wr_ctrl ##2 1'b1 |->
        CABLE_POWER_CURRENT_LIMIT == $past(REG_WDATA[typec_mux_pkg::CTRL_ILIM], 2))
        else $error("current limit setting not applied");

    AST_TRISTATE: assert property (xb_cfg && !xbar_q[typec_mux_pkg::XB_SER_TX*4+typec_mux_pkg::XB_OE]
        |=> !XB_PIN_OE[typec_mux_pkg::XB_SER_TX]) else $error("serial transmit not tri-stated");

    AST_AUX_ANALOG: assert property (aux_an && (sb_src == typec_mux_pkg::SRC_AUX_SERIAL)
        |=> AUX_ANALOG_PASS && (PORT_PIN_OE[typec_mux_pkg::PIN_SB_B:typec_mux_pkg::PIN_SB_A] == 2'h0))
        else $error("aux analog mode still drives sideband");

    AST_BYPASS: assert property ((age_q >= 4'h3) && !xb_cfg && !$past(xb_cfg)
        |-> XB_PIN_O[typec_mux_pkg::XB_SER_TX] == $past(XB_PIN_I[typec_mux_pkg::XB_SER_RX], 3)
        && XB_PIN_OE[typec_mux_pkg::XB_SER_TX]) else $error("power-up bypass broken");

    // Top positive pin is driven only while channel 0 owns the top pair
    AST_TOP_DRIVE: assert property (PORT_PIN_OE[typec_mux_pkg::PIN_TOP_POS]
        |-> SW_TOP_SEL == onehot(typec_mux_pkg::SRC_CORE_SERIAL))
        else $error("top pin driven without channel 0 closed");

    // Sideband pins are driven only by a buffered source that owns the pair
    AST_SB_DRIVE: assert property ((|PORT_PIN_OE[typec_mux_pkg::PIN_SB_B:typec_mux_pkg::PIN_SB_A])
        |-> (SW_SIDEBAND_SEL == onehot(typec_mux_pkg::SRC_CORE_SERIAL))
        || (SW_SIDEBAND_SEL == onehot(typec_mux_pkg::SRC_AUX_SERIAL)))
        else $error("sideband pin driven with no buffered source");

    // Second members, after crossing, are never driven
    AST_NEG_QUIET: assert property (!PORT_PIN_OE[typec_mux_pkg::PIN_TOP_NEG]
        && !PORT_PIN_OE[typec_mux_pkg::PIN_BOT_NEG]
        && !PORT_PIN_OE[SIDEBAND_CROSS ? typec_mux_pkg::PIN_SB_A : typec_mux_pkg::PIN_SB_B])
        else $error("second member pin driven");
endmodule

/* File: typec_port_data_mux_control_test.sv */
// Self-checking bench for the port data multiplexer control
`timescale 1ns/1ps
module typec_port_data_mux_control_test;
    logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, orient = 1'b0, rd_d = 1'b0;
    logic [7:0]  addr = 8'h00, sw_top, sw_bot, sw_sb;
    logic [31:0] wdata = 32'h0, rdata, lfsr = 32'h55BF, rd_q[$];
    logic        sb_cross, aux_an, ilim;
    logic [5:0]  pp_i, pp_o, pp_oe, xb_i, xb_o, xb_oe, pp_ext = 6'h00, xb_ext = 6'h00;
    int          miscompares = 0, n_checks = 0;
    logic [7:0]  exp_p, exp_s;                        // Expected pair closures
    // Design under test
    typec_port_data_mux_control uut (.CLK_SYS(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .ORIENT_FLIP(orient), .SW_TOP_SEL(sw_top),
        .SW_BOTTOM_SEL(sw_bot), .SW_SIDEBAND_SEL(sw_sb), .SIDEBAND_CROSS(sb_cross), .PORT_PIN_I(pp_i),
        .PORT_PIN_O(pp_o), .PORT_PIN_OE(pp_oe), .XB_PIN_I(xb_i), .XB_PIN_O(xb_o), .XB_PIN_OE(xb_oe),
        .AUX_ANALOG_PASS(aux_an), .CABLE_POWER_CURRENT_LIMIT(ilim));
    // Receptacle drives top_neg and sideband_a; system drives serial rx, aux system_to_port, gio1
    port_far_end pport (.clk(clk), .pin_o(pp_o), .pin_oe(pp_oe), .ext(pp_ext), .ext_en(6'h12), .pin_i(pp_i));
    port_far_end pxb (.clk(clk), .pin_o(xb_o), .pin_oe(xb_oe), .ext(xb_ext), .ext_en(6'h29), .pin_i(xb_i));
    // Clock at 25 ns
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Compare one value, count and report
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task summarize();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Pseudo-random source
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Register write, one strobe cycle
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Register read; expectation queued for the monitor
    task rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // Write strobe, then read strobe of the same register in the next cycle
    task wr_rd_reg(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // Wait edges, then let registered outputs settle
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Read data stands in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_d) begin
            check(rdata, rd_q.pop_front());
        end
        rd_d <= rd;
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize();
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        settle(2);
        check(xb_oe[1], 1);
        check({sw_top, sw_bot, sw_sb}, 0);
        rd_reg(8'h00, 0);
        rd_reg(8'h04, 0);
        rd_reg(8'h08, 0);
        rd_reg(8'h10, 0);
        // Power-up bypass: serial rx copied to tx
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            xb_ext[0] <= lfsr[0];
            lfsr = lfsr_next(lfsr);
            settle(4);
            check(xb_o[1], xb_ext[0]);
        end
        $display("test reset and bypass done");
        // Control bits
        for (int v = 0; v < 4; v++) begin
            wr_rd_reg(8'h04, 32'(v), 32'(v));
            settle(1);
            check(ilim, v & 1);
            check(aux_an, (v >> 1) & 1);
        end
        $display("test control done");
        // Every source code on primary and sideband, both orientations
        for (int o = 0; o < 2; o++) begin
            for (int s = 0; s < 10; s++) begin
                @(posedge clk);
                orient <= o[0];
                wr_reg(8'h00, {20'h0, s[3:0], 4'h0, s[3:0]});
                settle(2);
                exp_p = (s >= 1 && s <= 7) ? 8'h01 << (s - 1) : 8'h00;
                exp_s = (s >= 3 && s <= 8) ? 8'h01 << (s - 1) : 8'h00;
                check(sw_top, o ? 8'h00 : exp_p);
                check(sw_bot, o ? exp_p : 8'h00);
                check(sw_sb, exp_s);
                check(sb_cross, o);
                rd_reg(8'h0C, 32'(((s >= 3 && s <= 8) ? s << 12 : 0) | o |
                    ((s >= 1 && s <= 7) ? s << (o ? 8 : 4) : 0)));
            end
        end
        $display("test routing done");
        // Crossbar: gio0 out from ch0 rx, gio1 into ch0 tx, others unmapped
        @(posedge clk);
        orient <= 1'b0;
        wr_reg(8'h08, 32'h000CBB33);
        wr_reg(8'h04, 32'h4);
        wr_reg(8'h00, 32'h007);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            pp_ext[1] <= lfsr[0];
            xb_ext[5] <= lfsr[1];
            lfsr = lfsr_next(lfsr);
            settle(6);
            check(pp_oe[0], 1);
            check(pp_o[0], xb_ext[5]);
            check({xb_oe[4], xb_o[4]}, {1'b1, pp_ext[1]});
            check(xb_oe[1], 0);
        end
        rd_reg(8'h08, 32'h000CBB33);
        settle(2);
        $display("test crossbar done");
        // Aux serial buffered on the crossed sideband pair, then as analog pass
        @(posedge clk);
        orient <= 1'b1;
        wr_reg(8'h00, 32'h800);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            pp_ext[4] <= lfsr[0];
            xb_ext[3] <= lfsr[1];
            lfsr = lfsr_next(lfsr);
            settle(6);
            check({pp_oe[5:4], pp_o[5]}, {2'h2, xb_ext[3]});
            check({xb_oe[3:2], xb_o[2]}, {2'h1, pp_ext[4]});
        end
        wr_reg(8'h04, 32'h6);
        settle(2);
        check({aux_an, pp_oe[5:4], xb_oe[3:2]}, 5'h10);
        $display("test aux serial done");
        summarize();
    end
endmodule
